// ---- hdl/epl_position_monitor.sv ----
// encoder decoding, load angle supervision, follower and buffered pulse ramping
module epl_position_monitor
  import epl_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int VEL_W = 16
)(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  // first encoder input (after line receiver)
  input  wire logic                    enc1ChanA,
  input  wire logic                    enc1ChanB,
  // second encoder input from general digital inputs
  input  wire logic                    secondEncoderChannelAInput,
  input  wire logic                    secondEncoderChannelBInput,
  // input configuration
  input  wire logic [1:0]              enc1Mode,
  input  wire logic [1:0]              enc2Mode,
  input  wire logic                    enc1Use,
  input  wire logic                    followEnable,
  input  wire logic                    followSource,
  input  wire logic signed [15:0]      gearRatio,
  input  wire logic [15:0]             pulseDist,
  input  wire logic [7:0]              countsPerStep,
  // supervision configuration
  input  wire logic [POS_W-1:0]        devLimit,
  input  wire logic                    errorSelect,
  input  wire logic                    recoverySelect,
  input  wire logic                    closedLoopFitted,
  input  wire logic [POS_W-1:0]        closedThresh,
  // motion profile
  input  wire logic [VEL_W-1:0]        accel,
  input  wire logic [VEL_W-1:0]        maxVel,
  input  wire logic [VEL_W-1:0]        homingVel,
  input  wire logic signed [POS_W-1:0] targetPos,
  // commands, one-cycle pulses
  input  wire logic                    moveStart,
  input  wire logic                    recoverStart,
  input  wire logic                    clearError,
  input  wire logic                    clearWarning,
  // motor drive
  output logic                         motorStep,
  output logic                         motorDir,
  // status
  output logic signed [POS_W-1:0]      encoderPos,
  output logic signed [POS_W-1:0]      commandPos,
  output logic signed [POS_W-1:0]      deviation,
  output logic                         loadAngleError,
  output logic                         loadAngleWarning,
  output logic                         closedLoopActive,
  output logic                         moving
);

  function automatic logic [POS_W-1:0] magnitude(input logic signed [POS_W-1:0] v);
    return v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
  endfunction

  epl_motion_e               state;
  epl_motion_e               next_state;
  logic                      up1, dn1, up2, dn2;
  logic                      srcUp, srcDn, srcIsQuad;
  logic signed [POS_W-1:0]   goal;
  logic signed [POS_W-1:0]   rem;
  logic signed [POS_W-1:0]   dev;
  logic signed [POS_W-1:0]   followScale;
  logic signed [POS_W-1:0]   stepSize;
  logic [POS_W-1:0]          absRem, absDev, brakeDist;
  logic [VEL_W-1:0]          vel, vlim;
  logic [VEL_W-1:0]          phase;
  logic [VEL_W:0]            phaseSum, velSum;
  logic [RAMP_CNT_W-1:0]     rampCount;
  logic                      rampTick, haveDist, remDir, wrongDir, decel;
  logic                      clBlock, stepNow, devExceeded, stopEvent;
  logic                      followEvent, recoverMove, recoverOverwrite, velZero;

  // decoders for both inputs
  epl_input_decoder u_enc1 (
    .mclk      (mclk),
    .rstn      (rstn),
    .chanA     (enc1ChanA),
    .chanB     (enc1ChanB),
    .mode      (enc1Mode),
    .countUp   (up1),
    .countDown (dn1)
  );

  epl_input_decoder u_enc2 (
    .mclk      (mclk),
    .rstn      (rstn),
    .chanA     (secondEncoderChannelAInput),
    .chanB     (secondEncoderChannelBInput),
    .mode      (enc2Mode),
    .countUp   (up2),
    .countDown (dn2)
  );

  // follower source: the first input only when not busy supervising
  always_comb begin
    if (followSource == SRC_FIRST && enc1Use == USE_FOLLOW) begin
      srcUp     = up1;
      srcDn     = dn1;
      srcIsQuad = (enc1Mode == MODE_QUAD);
    end else begin
      srcUp     = up2;
      srcDn     = dn2;
      srcIsQuad = (enc2Mode == MODE_QUAD);
    end
  end

  // encoder counts scale by gear ratio, pulses by distance per pulse
  assign followScale = srcIsQuad ? POS_W'(gearRatio)
                                 : signed'(POS_W'(pulseDist));
  assign followEvent = followEnable && (srcUp || srcDn) && !loadAngleError
                       && state != ST_HALT;
  assign stepSize    = signed'(POS_W'(countsPerStep));

  // distance still buffered between goal and command
  assign rem      = goal - commandPos;
  assign absRem   = magnitude(rem);
  assign remDir   = !rem[POS_W-1];
  assign haveDist = absRem >= POS_W'(countsPerStep) && countsPerStep != 8'h00;
  assign velZero  = (vel == '0);
  assign wrongDir = !velZero && haveDist && remDir != motorDir;

  // following difference between command and measured position
  assign dev         = commandPos - encoderPos;
  assign absDev      = magnitude(dev);
  assign devExceeded = enc1Use == USE_SUPERVISE && absDev > devLimit;
  assign stopEvent   = devExceeded && errorSelect && !loadAngleError;

  assign recoverMove      = recoverStart && loadAngleError && state == ST_IDLE
                            && recoverySelect == REC_MOVE;
  assign recoverOverwrite = recoverStart && loadAngleError && state == ST_IDLE
                            && recoverySelect == REC_OVERWRITE;

  // ramp tick divider
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rampCount <= '0;
    end else if (rampTick) begin
      rampCount <= '0;
    end else begin
      rampCount <= rampCount + RAMP_CNT_W'(1);
    end
  end

  assign rampTick = (rampCount == RAMP_CYCLES - RAMP_CNT_W'(1));

  // braking begins when remaining distance fits the distance stepped while not braking
  assign decel = state == ST_HALT || wrongDir || !haveDist || absRem <= brakeDist;
  assign vlim  = (state == ST_RECOVER) ? homingVel : maxVel;

  // closed loop holds steps that would widen the lag
  assign clBlock  = closedLoopActive && (motorDir == !dev[POS_W-1]) && dev != '0;
  assign phaseSum = {1'b0, phase} + {1'b0, vel};
  assign stepNow  = phaseSum[VEL_W] && !clBlock &&
                    (state == ST_HALT || (!wrongDir && haveDist));
  assign velSum   = {1'b0, vel} + {1'b0, accel};

  // velocity ramp, bounded by acceleration and limit
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      vel <= '0;
    end else if (rampTick) begin
      if (decel) begin
        vel <= (vel > accel) ? vel - accel : '0;
      end else if (velSum > {1'b0, vlim}) begin
        vel <= vlim;
      end else begin
        vel <= velSum[VEL_W-1:0];
      end
    end
  end

  // step phase accumulator and step output
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase     <= '0;
      motorStep <= 1'b0;
    end else begin
      phase     <= velZero ? '0 : phaseSum[VEL_W-1:0];
      motorStep <= stepNow;
    end
  end

  // direction only turns at standstill so no step reversal under speed
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      motorDir <= DIR_RESET;
    end else if (velZero && haveDist && state != ST_HALT) begin
      motorDir <= remDir;
    end
  end

  // distance needed to stop, grown on every step taken while not braking
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      brakeDist <= '0;
    end else if (velZero) begin
      brakeDist <= '0;
    end else if (stepNow) begin
      if (!decel) begin
        brakeDist <= brakeDist + POS_W'(countsPerStep);
      end else if (brakeDist > POS_W'(countsPerStep)) begin
        brakeDist <= brakeDist - POS_W'(countsPerStep);
      end else begin
        brakeDist <= '0;
      end
    end
  end

  // measured position from the first input in supervision use, quadrature format only
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      encoderPos <= '0;
    end else if (enc1Use == USE_SUPERVISE && enc1Mode == MODE_QUAD) begin
      if (up1) begin
        encoderPos <= encoderPos + POS_W'(1);
      end else if (dn1) begin
        encoderPos <= encoderPos - POS_W'(1);
      end
    end
  end

  // command position tracks issued steps
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      commandPos <= '0;
    end else if (recoverOverwrite) begin
      commandPos <= encoderPos;
    end else if (stepNow) begin
      commandPos <= motorDir ? commandPos + stepSize : commandPos - stepSize;
    end
  end

  // goal holds the buffered pulse and follower distance
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      goal <= '0;
    end else if (state == ST_HALT && velZero) begin
      goal <= commandPos; // drop what was buffered at the stop
    end else if (recoverOverwrite) begin
      goal <= encoderPos;
    end else if (recoverMove) begin
      goal <= targetPos;
    end else if (moveStart && !loadAngleError && state != ST_HALT) begin
      goal <= targetPos;
    end else if (followEvent) begin
      goal <= srcUp ? goal + followScale : goal - followScale;
    end
  end

  // motion sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (stopEvent) next_state = ST_HALT;
        else if (recoverMove) next_state = ST_RECOVER;
        else if (haveDist) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (stopEvent) next_state = ST_HALT;
        else if (velZero && !haveDist) next_state = ST_IDLE;
      end
      ST_HALT: begin
        if (velZero) next_state = ST_IDLE;
      end
      ST_RECOVER: begin
        if (stopEvent) next_state = ST_HALT;
        else if (velZero && !haveDist) next_state = ST_IDLE;
      end
      default: next_state = ST_HALT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      loadAngleError   <= 1'b0;
      loadAngleWarning <= 1'b0;
    end else begin
      if (devExceeded && errorSelect) loadAngleError <= 1'b1;
      else if (clearError) loadAngleError <= 1'b0;
      if (devExceeded && !errorSelect) loadAngleWarning <= 1'b1;
      else if (clearWarning) loadAngleWarning <= 1'b0;
    end
  end

  // registered status views
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      deviation        <= '0;
      closedLoopActive <= 1'b0;
      moving           <= 1'b0;
    end else begin
      deviation        <= dev;
      // threshold is the lag in counts equal to the full-step angle
      closedLoopActive <= closedLoopFitted && absDev >= closedThresh;
      moving           <= !velZero;
    end
  end

endmodule

// ---- hdl/epl_pkg.sv ----
package epl_pkg;

  // input decoder formats
  localparam logic [1:0] MODE_QUAD      = 2'h0;
  localparam logic [1:0] MODE_PULSE_DIR = 2'h1;
  localparam logic [1:0] MODE_UP_DOWN   = 2'h2;

  // use of the first encoder input
  localparam logic       USE_SUPERVISE  = 1'b0;
  localparam logic       USE_FOLLOW     = 1'b1;

  // follower source select
  localparam logic       SRC_FIRST      = 1'b0;
  localparam logic       SRC_SECOND     = 1'b1;

  // recovery after a deviation error
  localparam logic       REC_MOVE       = 1'b0;
  localparam logic       REC_OVERWRITE  = 1'b1;

  // ramp update period
  localparam int         CLK_KHZ        = 25000;
  localparam int         RAMP_TICK_US   = 100;
  localparam int         RAMP_CNT_W     = 12;
  localparam logic [RAMP_CNT_W-1:0] RAMP_CYCLES =
    RAMP_CNT_W'(RAMP_TICK_US * CLK_KHZ / 1000);

  // motion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_HALT    = 4'b0100,
    ST_RECOVER = 4'b1000
  } epl_motion_e;

  localparam epl_motion_e STATE_RESET = ST_IDLE;
  localparam logic        DIR_RESET   = 1'b1;

endpackage

// ---- hdl/epl_input_decoder.sv ----
// turns an A/B pair into count-up / count-down pulses in one of three formats
module epl_input_decoder
  import epl_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // channels and format
  input  wire logic       chanA,
  input  wire logic       chanB,
  input  wire logic [1:0] mode,
  // count events
  output logic            countUp,
  output logic            countDown
);

  logic prevA;
  logic prevB;
  logic aChg;
  logic bChg;

  // previous channel levels for edge and transition detection
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prevA <= 1'b0;
      prevB <= 1'b0;
    end else begin
      prevA <= chanA;
      prevB <= chanB;
    end
  end

  assign aChg = chanA ^ prevA;
  assign bChg = chanB ^ prevB;

  // event decode; complementary lines are never looked at here
  always_comb begin
    countUp   = 1'b0;
    countDown = 1'b0;
    unique case (mode)
      MODE_QUAD: begin
        // one channel changed: direction from phase order, both changed: glitch
        if (aChg ^ bChg) begin
          countUp   = chanA ^ prevB;
          countDown = ~(chanA ^ prevB);
        end
      end
      MODE_PULSE_DIR: begin
        // pulse on A rising edge, B high means positive
        countUp   = chanA & ~prevA & chanB;
        countDown = chanA & ~prevA & ~chanB;
      end
      MODE_UP_DOWN: begin
        // simultaneous pulses cancel each other
        countUp   = chanA & ~prevA & ~(chanB & ~prevB);
        countDown = chanB & ~prevB & ~(chanA & ~prevA);
      end
      default: begin
        countUp   = 1'b0;
        countDown = 1'b0;
      end
    endcase
  end

endmodule

// ---- test/epl_enc_model.sv ----
// stands in for an incremental encoder, hand wheel or pulse source
module epl_enc_model (
  // clock, only used to space the edges
  input  wire logic mclk,
  // encoder lines
  output logic      chA,
  output logic      chB
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;

  // lines start low, matching the decoder's reset levels
  initial begin
    chA = 1'b0;
    chB = 1'b0;
  end

  // quadrature phase to levels; A leads when counting up
  task automatic put(input int p);
    ph = p;
    chA = p == 1 || p == 2;
    chB = p >= 2;
  endtask

  // one gray step per count, two clocks apart
  task automatic step(input int n);
    repeat (n < 0 ? -n : n) begin
      @(negedge mclk);
      put((ph + (n < 0 ? 3 : 1)) % 4);
      @(negedge mclk);
    end
  endtask

  // both lines flip in one clock, which a decoder must drop
  task automatic glitch();
    @(negedge mclk);
    put((ph + 2) % 4);
    @(negedge mclk);
  endtask

  // second line settles a clock before the rising pulse
  task automatic pulse(input logic dir);
    @(negedge mclk);
    chB = dir;
    chA = 1'b0;
    @(negedge mclk);
    chA = 1'b1;
    @(negedge mclk);
  endtask
endmodule

// ---- test/epl_position_monitor_chk.sv ----
// watches the monitor's ports
module epl_position_monitor_chk
  import epl_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int VEL_W = 16
)(
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rstn,
  // inputs
  input wire logic                    enc1ChanA,
  input wire logic                    enc1ChanB,
  input wire logic [1:0]              enc1Mode,
  input wire logic                    enc1Use,
  input wire logic [7:0]              countsPerStep,
  input wire logic [POS_W-1:0]        devLimit,
  input wire logic                    errorSelect,
  input wire logic                    recoverySelect,
  input wire logic                    closedLoopFitted,
  input wire logic [POS_W-1:0]        closedThresh,
  input wire logic                    recoverStart,
  // outputs
  input wire logic                    motorStep,
  input wire logic                    motorDir,
  input wire logic signed [POS_W-1:0] encoderPos,
  input wire logic signed [POS_W-1:0] commandPos,
  input wire logic                    loadAngleError,
  input wire logic                    closedLoopActive,
  input wire logic                    moving
);
  logic signed [POS_W-1:0] diff;
  logic        [POS_W-1:0] absDev;
  logic                    quadWatch;

  // size of the deviation; the design may lag it by a register, hence the ranges
  assign diff = commandPos - encoderPos;
  assign absDev = diff < 0 ? -diff : diff;
  assign quadWatch = enc1Mode == MODE_QUAD && enc1Use == USE_SUPERVISE;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_step_fwd: assert property (
    motorStep && motorDir |-> commandPos == $past(commandPos) + countsPerStep)
    else $error("step did not advance command");
  a_quad_up: assert property (
    quadWatch && $rose(enc1ChanA) && !enc1ChanB && $stable(enc1ChanB)
    |=> encoderPos == $past(encoderPos) + 1)
    else $error("quadrature up count missed");
  a_quad_double: assert property (
    quadWatch && $changed(enc1ChanA) && $changed(enc1ChanB) |=> $stable(encoderPos))
    else $error("double change was counted");
  a_err_set: assert property (
    enc1Use == USE_SUPERVISE && errorSelect && absDev > devLimit |-> ##[1:3] loadAngleError)
    else $error("deviation error not raised");
  a_halt_quiet: assert property (
    (loadAngleError && !moving) [*2] |-> !motorStep)
    else $error("step while stopped on error");
  a_overwrite: assert property (
    recoverStart && recoverySelect && loadAngleError && !moving
    |=> commandPos == $past(encoderPos))
    else $error("command not overwritten");
  a_closed_on: assert property (
    closedLoopFitted && absDev >= closedThresh |-> ##[1:3] closedLoopActive)
    else $error("closed loop not entered");
  a_open_stay: assert property (
    (!closedLoopFitted || absDev < closedThresh) [*3] |-> !closedLoopActive)
    else $error("closed loop below threshold");
endmodule

bind epl_position_monitor epl_position_monitor_chk #(.POS_W(POS_W), .VEL_W(VEL_W)) chk (
  .mclk, .rstn, .enc1ChanA, .enc1ChanB, .enc1Mode, .enc1Use, .countsPerStep, .devLimit,
  .errorSelect, .recoverySelect, .closedLoopFitted, .closedThresh, .recoverStart,
  .motorStep, .motorDir, .encoderPos, .commandPos, .loadAngleError, .closedLoopActive,
  .moving);

// ---- test/epl_position_monitor_tb.sv ----
module epl_position_monitor_tb
  import epl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic               mclk, rstn, enc1ChanA, enc1ChanB, enc1Use, followEnable;
  logic               followSource, errorSelect, recoverySelect, closedLoopFitted;
  logic               moveStart, recoverStart, clearError, clearWarning, motorStep;
  logic               motorDir, loadAngleError, loadAngleWarning, closedLoopActive, moving;
  logic               secondEncoderChannelAInput, secondEncoderChannelBInput;
  logic [1:0]         enc1Mode, enc2Mode;
  logic [7:0]         countsPerStep;
  logic [15:0]        pulseDist, accel, maxVel, homingVel;
  logic signed [15:0] gearRatio;
  logic [31:0]        devLimit, closedThresh;
  logic signed [31:0] targetPos, encoderPos, commandPos, deviation;
  int                 nErrors = 0;
  int                 checksDone = 0;
  int                 cycles = 0;

  epl_position_monitor i_epl_position_monitor (
    .mclk, .rstn, .enc1ChanA, .enc1ChanB, .secondEncoderChannelAInput,
    .secondEncoderChannelBInput, .enc1Mode, .enc2Mode, .enc1Use, .followEnable,
    .followSource, .gearRatio, .pulseDist, .countsPerStep, .devLimit, .errorSelect,
    .recoverySelect, .closedLoopFitted, .closedThresh, .accel, .maxVel, .homingVel,
    .targetPos, .moveStart, .recoverStart, .clearError, .clearWarning, .motorStep,
    .motorDir, .encoderPos, .commandPos, .deviation, .loadAngleError, .loadAngleWarning,
    .closedLoopActive, .moving);

  // motor encoder on the first input, wheel or pulse source on the second
  epl_enc_model enc1Src (.mclk, .chA(enc1ChanA), .chB(enc1ChanB));
  epl_enc_model enc2Src (.mclk, .chA(secondEncoderChannelAInput),
    .chB(secondEncoderChannelBInput));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // hang guard, well above the longest ramped moves
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      nErrors = nErrors + 1;
      closeOut();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle command pulse
  task automatic kick(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  // ramped moves take thousands of clocks, so the wait is bounded generously
  task automatic waitCmd(input logic [31:0] exp);
    for (int i = 0; i < 20000 && commandPos !== exp; i++) @(negedge mclk);
    chk("commandPos", exp, commandPos);
  endtask

  // velocity only drops at a ramp tick, so standstill can take a full tick period
  task automatic waitStill();
    for (int i = 0; i < 3000 && moving !== 1'b0; i++) @(negedge mclk);
  endtask

  task automatic testReset();
    chk("motorStep", 32'h0, motorStep);
    chk("motorDir", {31'h0, DIR_RESET}, motorDir);
    chk("commandPos", 32'h0, commandPos);
    chk("moving", 32'h0, moving);
    $display("test reset done");
  endtask

  // counts both ways, drops a double change; supervision use feeds no follower
  task automatic testQuad();
    countsPerStep = 8'h01;
    followEnable = 1'b1;
    followSource = SRC_FIRST;
    enc1Src.step(5);
    enc1Src.step(-2);
    enc1Src.glitch();
    repeat (3000) @(negedge mclk);
    chk("encoderPos", 32'h3, encoderPos);
    chk("commandPos", 32'h0, commandPos);
    $display("test quad done");
  endtask

  task automatic testFollow();
    followSource = SRC_SECOND;
    enc2Src.step(1);
    waitCmd(32'h3);
    targetPos = 32'h1;
    accel = 16'h0800;
    kick(moveStart);
    waitCmd(32'h1);
    pulseDist = 16'h0003;
    enc2Mode = MODE_PULSE_DIR;
    enc2Src.pulse(1'b0);
    waitCmd(32'hFFFFFFFE);
    chk("motorDir", 32'h0, motorDir);
    enc2Mode = MODE_UP_DOWN;
    enc2Src.pulse(1'b0);
    waitCmd(32'h1);
    $display("test follow done");
  endtask

  task automatic testSupervise();
    devLimit = 32'h1;
    repeat (4) @(negedge mclk);
    chk("loadAngleError", 32'h1, loadAngleError);
    // the motor is still at speed here, so the halt overshoots while braking
    waitStill();
    chk("moving", 32'h0, moving);
    // move recovery drives back to the held target of 1
    kick(recoverStart);
    waitCmd(32'h1);
    waitStill();
    recoverySelect = REC_OVERWRITE;
    kick(recoverStart);
    @(negedge mclk);
    chk("commandPos", 32'h3, commandPos);
    kick(clearError);
    errorSelect = 1'b0;
    enc1Src.step(2);
    kick(clearWarning);
    repeat (3) @(negedge mclk);
    chk("loadAngleWarning", 32'h1, loadAngleWarning);
    chk("loadAngleError", 32'h0, loadAngleError);
    closedLoopFitted = 1'b1;
    closedThresh = 32'h2;
    repeat (4) @(negedge mclk);
    chk("closedLoopActive", 32'h1, closedLoopActive);
    chk("deviation", 32'hFFFFFFFE, deviation);
    closedThresh = 32'h3;
    repeat (4) @(negedge mclk);
    chk("closedLoopActive", 32'h0, closedLoopActive);
    $display("test supervise done");
  endtask

  // first input as a pulse/direction follower source; it no longer measures
  task automatic testFirstPulse();
    closedLoopFitted = 1'b0;
    enc1Use = USE_FOLLOW;
    followSource = SRC_FIRST;
    enc1Mode = MODE_PULSE_DIR;
    enc1Src.pulse(1'b1);
    waitCmd(32'h6);
    chk("encoderPos", 32'h5, encoderPos);
    $display("test first pulse done");
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    enc1Mode = MODE_QUAD;
    enc2Mode = MODE_QUAD;
    enc1Use = USE_SUPERVISE;
    followEnable = 1'b0;
    followSource = SRC_SECOND;
    gearRatio = 16'h0003;
    pulseDist = 16'h0000;
    countsPerStep = 8'h00;
    devLimit = 32'h000003E8;
    errorSelect = 1'b1;
    recoverySelect = REC_MOVE;
    closedLoopFitted = 1'b0;
    closedThresh = 32'h0;
    accel = 16'h1000;
    maxVel = 16'h2000;
    homingVel = 16'h0800;
    targetPos = 32'h0;
    moveStart = 1'b0;
    recoverStart = 1'b0;
    clearError = 1'b0;
    clearWarning = 1'b0;
    repeat (12) @(negedge mclk);
    testReset();
    rstn = 1'b1;
    testQuad();
    testFollow();
    testSupervise();
    testFirstPulse();
    closeOut();
  end
endmodule
